// ### core/oplff_framer.sv
`timescale 1ns/1ps
`default_nettype none
module oplff_framer
#(
    parameter logic [13:0] SYNC_WORD = 14'h3F00
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // transmit payload and line
    input wire logic tx_pay_bit,
    input wire logic app_bit_strobe,
    output logic tx_pay_take,
    output logic tx_line_bit,
    // receive line and payload
    input wire logic rx_line_bit,
    input wire logic rx_frame_start,
    output logic rx_pay_bit,
    output logic rx_pay_valid,
    // quality estimate from the receiver
    input wire logic [7:0] signal_quality_estimate
);
    import oplff_pkg::*;

    typedef struct packed {
        logic [13:0] pos;
        logic take;
        logic line;
        logic [15:0] txcnt;
        logic [13:0] rpos;
        logic [50:1] rhoh;
        logic rpv;
        logic rpb;
        logic [15:0] rxcnt;
        logic [3:0] rgap;
        logic dw;
        logic [7:0] da;
        logic [31:0] rdata;
        logic rdy;
        logic resp;
        logic [14:0] ctrl;
        logic [18:0] txovh;
        logic [7:0] sq;
    } oplff_state_s;

    oplff_state_s s;
    oplff_state_s n;
    logic [50:0] hv;
    logic [13:0] rp;
    logic [13:0] flen;
    logic [5:0] tidx;
    logic [5:0] ridx;
    logic [1:0] pairs;
    logic signed [15:0] phase;
    logic en;
    logic decide;
    logic consume;
    logic acc;

    assign en = s.ctrl[CTL_EN];
    assign decide = en && s.pos == POS_DECIDE;
    assign consume = en && s.take;
    assign flen = POS_PAY_LAST + {11'h000, pairs, 1'b0};

    // phase tracking and pad pair choice
    oplff_stuff_ctl u_stuff
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .arrive(app_bit_strobe),
        .consume(consume),
        .decide(decide),
        .pairs(pairs),
        .phase(phase)
    );

    // overhead bits to send, indexed by overhead bit number
    always_comb
    begin
        hv = '0;
        for (int i = 1; i <= 14; i++)
            hv[i] = SYNC_WORD[14 - i];
        hv[15] = s.ctrl[CTL_LOSD];
        hv[16] = s.ctrl[CTL_FEBE];
        hv[20:17] = s.txovh[3:0];
        hv[22:21] = s.txovh[TXO_CRC +: 2];
        hv[23] = s.ctrl[CTL_NTU] ? s.ctrl[CTL_PSA] : IDLE_BIT;
        hv[24] = s.ctrl[CTL_NTU] ? s.ctrl[CTL_PSB] : IDLE_BIT;
        hv[25] = s.ctrl[CTL_BPV];
        hv[26] = s.txovh[4];
        hv[30:27] = s.txovh[8:5];
        hv[32:31] = s.txovh[TXO_CRC + 2 +: 2];
        hv[36:33] = s.ctrl[CTL_REGEN +: 4];
        hv[40:37] = s.txovh[12:9];
        hv[42:41] = s.txovh[TXO_CRC + 4 +: 2];
        hv[43] = s.ctrl[CTL_RTA];
        hv[44] = s.ctrl[CTL_READY];
        hv[46:45] = s.ctrl[CTL_UIB +: 2];
        hv[50:47] = {4{STUFF_BIT}};
    end

    // next state: transmit framer, receive parser, register slave
    always_comb
    begin
        n = s;
        tidx = hoh_index(s.pos);
        // transmit: one line bit per clock, payload taken where no overhead sits
        if (en)
        begin
            n.line = s.take ? tx_pay_bit : hv[tidx];
            if (s.pos >= flen)
            begin
                n.pos = POS_FIRST;
                n.txcnt = s.txcnt + 16'h0001;
            end
            else
                n.pos = s.pos + 14'h0001;
        end
        else
        begin
            n.line = IDLE_BIT;
            n.pos = POS_FIRST;
        end
        // receive: count from the frame start mark and sort each bit
        if (rx_frame_start)
            rp = POS_FIRST;
        else if (s.rpos == 14'h0000 || s.rpos == POS_MAX)
            rp = 14'h0000;
        else
            rp = s.rpos + 14'h0001;
        ridx = hoh_index(rp);
        n.rpos = rp;
        n.rpv = 1'b0;
        if (rp != 14'h0000)
        begin
            if (ridx == 6'h00)
            begin
                n.rpb = rx_line_bit;
                n.rpv = 1'b1;
            end
            else
                n.rhoh[ridx] = rx_line_bit;
        end
        if (rx_frame_start)
            n.rxcnt = s.rxcnt + 16'h0001;
        // cycles since the last frame start mark, held at its top value
        if (rx_frame_start)
            n.rgap = 4'h1;
        else if (s.rgap != 4'h0 && s.rgap != 4'hF)
            n.rgap = s.rgap + 4'h1;
        n.sq = signal_quality_estimate;
        // register slave: zero wait states, write data taken in the data phase
        acc = hsel && hready && htrans[1];
        n.rdy = 1'b1;
        n.resp = 1'b0;
        if (s.dw)
        begin
            case (s.da)
                ADDR_CTRL: n.ctrl = hwdata[14:0];
                ADDR_TXOVH: n.txovh = hwdata[18:0];
                default: n.txovh = n.txovh;
            endcase
        end
        n.dw = acc && hwrite;
        if (acc)
            n.da = {haddr[7:2], 2'b00};
        if (acc && !hwrite)
        begin
            case ({haddr[7:2], 2'b00})
                ADDR_CTRL: n.rdata = {17'h00000, s.ctrl};
                ADDR_TXOVH: n.rdata = {13'h0000, s.txovh};
                ADDR_RXOVH: n.rdata = s.rhoh[46:15];
                ADDR_STATUS: n.rdata = {s.txcnt, 6'h00, pairs, s.sq};
                ADDR_PHASE: n.rdata = {s.rxcnt, phase};
                default: n.rdata = 32'h00000000;
            endcase
        end
        // take follows the control value that holds next cycle, so a disable stops it at once
        n.take = n.ctrl[CTL_EN] && hoh_index(n.pos) == 6'h00 && n.pos <= POS_PAY_LAST;
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0;
            s.pos <= POS_FIRST;
            s.line <= IDLE_BIT;
            s.rdy <= 1'b1;
            s.ctrl <= CTRL_RST;
            s.txovh <= TXOVH_RST;
        end
        else
            s <= n;
    end

    // outputs straight from the state register
    assign hrdata = s.rdata;
    assign hreadyout = s.rdy;
    assign hresp = s.resp;
    assign tx_pay_take = s.take;
    assign tx_line_bit = s.line;
    assign rx_pay_bit = s.rpb;
    assign rx_pay_valid = s.rpv;

    // helper: expected sync bit for the position being sent
    logic exp_sync;
    assign exp_sync = SYNC_WORD[4'(POS_SYNC_LAST - s.pos)];

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence seq_payload_end;
        en && s.pos == POS_PAY_LAST && s.take;
    endsequence
    sequence seq_rx_bit15;
        !rx_frame_start && s.rgap == 4'hE;
    endsequence

    chk_frame_length: assert property ((en && $past(en) && s.pos == POS_FIRST && $past(s.pos) != POS_FIRST)
        |-> ($past(s.pos) == POS_PAY_LAST || $past(s.pos) == POS_PAY_LAST + 14'h0002 || $past(s.pos) == POS_MAX))
        else $error("frame length not 13918, 13920 or 13922");
    chk_pay_edge: assert property (seq_payload_end |=> (!s.take) [*2])
        else $error("payload taken in pad positions");
    chk_pay_ovh: assert property ((en && hoh_index(s.pos) != 6'h00) |-> !s.take)
        else $error("payload taken in overhead position");
    chk_losd_bit: assert property ((en && s.pos == POS_LOSD) |=> s.line == $past(s.ctrl[CTL_LOSD]))
        else $error("loss of input bit misplaced");
    chk_power_ltu: assert property ((en && !s.ctrl[CTL_NTU] && (s.pos == POS_PS_A || s.pos == POS_PS_B))
        |=> s.line == IDLE_BIT)
        else $error("power status sent toward network terminal");
    chk_ready_bit: assert property ((en && s.pos == POS_READY) |=> s.line == $past(s.ctrl[CTL_READY]))
        else $error("ready bit misplaced");
    chk_sync_word: assert property ((en && s.pos <= POS_SYNC_LAST) |=> s.line == $past(exp_sync))
        else $error("sync pattern bit wrong");
    chk_sq_report: assert property ($past(hresetn) |-> s.sq == $past(signal_quality_estimate))
        else $error("quality estimate not reported");
    chk_rx_losd: assert property (seq_rx_bit15 |=> s.rhoh[15] == $past(rx_line_bit))
        else $error("received loss of input bit not extracted");

endmodule : oplff_framer
`default_nettype wire

// ### core/oplff_pkg.sv
package oplff_pkg;

    // frame bit positions, numbered from one
    localparam logic [13:0] POS_FIRST = 14'h0001;
    localparam logic [13:0] POS_SYNC_LAST = 14'h000E;
    localparam logic [13:0] POS_LOSD = 14'h000F;
    localparam logic [13:0] POS_FEBE = 14'h0010;
    localparam logic [13:0] POS_GRP1 = 14'h0D9D;
    localparam logic [13:0] POS_PS_A = 14'h0DA3;
    localparam logic [13:0] POS_PS_B = 14'h0DA4;
    localparam logic [13:0] POS_GRP2 = 14'h1B33;
    localparam logic [13:0] POS_GRP3 = 14'h28C9;
    localparam logic [13:0] POS_READY = 14'h28D0;
    localparam logic [13:0] POS_DECIDE = 14'h365D;
    localparam logic [13:0] POS_PAY_LAST = 14'h365E;
    localparam logic [13:0] POS_STUFF = 14'h365F;
    localparam logic [13:0] POS_MAX = 14'h3662;
    localparam logic [13:0] GRP_LEN = 14'h000A;

    // overhead bit numbers at the start of each group
    localparam logic [13:0] HOH_GRP1 = 14'h0011;
    localparam logic [13:0] HOH_GRP2 = 14'h001B;
    localparam logic [13:0] HOH_GRP3 = 14'h0025;
    localparam logic [13:0] HOH_STUFF = 14'h002F;

    // fill values for stuffing and for a disabled transmitter
    localparam logic STUFF_BIT = 1'b1;
    localparam logic IDLE_BIT = 1'b1;

    // stuffing decision
    localparam logic signed [15:0] PHASE_LIMIT = 16'sh0002;
    localparam logic [1:0] PAIRS_NONE = 2'h0;
    localparam logic [1:0] PAIRS_NOMINAL = 2'h1;
    localparam logic [1:0] PAIRS_BOTH = 2'h2;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TXOVH = 8'h04;
    localparam logic [7:0] ADDR_RXOVH = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_PHASE = 8'h10;

    // control register fields
    localparam int CTL_EN = 0;
    localparam int CTL_NTU = 1;
    localparam int CTL_LOSD = 2;
    localparam int CTL_FEBE = 3;
    localparam int CTL_PSA = 4;
    localparam int CTL_PSB = 5;
    localparam int CTL_BPV = 6;
    localparam int CTL_RTA = 7;
    localparam int CTL_READY = 8;
    localparam int CTL_UIB = 9;
    localparam int CTL_REGEN = 11;
    localparam logic [14:0] CTRL_RST = 15'h0000;

    // transmit eoc and crc fields
    localparam int TXO_CRC = 13;
    localparam logic [18:0] TXOVH_RST = 19'h00000;

    // maps a frame position to its overhead bit number, zero for payload
    function automatic logic [5:0] hoh_index(input logic [13:0] p);
        logic [13:0] d;
        d = 14'h0000;
        if (p >= POS_FIRST && p <= POS_FEBE)
            d = p;
        else if (p >= POS_GRP1 && p < POS_GRP1 + GRP_LEN)
            d = p - POS_GRP1 + HOH_GRP1;
        else if (p >= POS_GRP2 && p < POS_GRP2 + GRP_LEN)
            d = p - POS_GRP2 + HOH_GRP2;
        else if (p >= POS_GRP3 && p < POS_GRP3 + GRP_LEN)
            d = p - POS_GRP3 + HOH_GRP3;
        else if (p >= POS_STUFF && p <= POS_MAX)
            d = p - POS_STUFF + HOH_STUFF;
        return d[5:0];
    endfunction : hoh_index

endpackage : oplff_pkg

// ### core/oplff_stuff_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module oplff_stuff_ctl
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // phase events
    input wire logic arrive,
    input wire logic consume,
    input wire logic decide,
    // decision
    output logic [1:0] pairs,
    output logic signed [15:0] phase
);
    import oplff_pkg::*;

    typedef struct packed {
        logic signed [15:0] phase;
        logic [1:0] pairs;
    } oplff_stuff_s;

    oplff_stuff_s s;
    oplff_stuff_s n;

    // track input backlog and choose the pad pairs once per frame
    always_comb
    begin
        n = s;
        if (arrive && !consume)
            n.phase = s.phase + 16'sh0001;
        else if (consume && !arrive)
            n.phase = s.phase - 16'sh0001;
        if (decide)
        begin
            if (s.phase > PHASE_LIMIT)
                n.pairs = PAIRS_NONE;
            else if (s.phase < -PHASE_LIMIT)
                n.pairs = PAIRS_BOTH;
            else
                n.pairs = PAIRS_NOMINAL;
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s <= '{phase: 16'sh0000, pairs: PAIRS_NOMINAL};
        else
            s <= n;
    end

    assign pairs = s.pairs;
    assign phase = s.phase;

    chk_stuff_range: assert property (@(posedge hclk) disable iff (!hresetn) s.pairs <= PAIRS_BOTH)
        else $error("pad pair count out of range");
    chk_stuff_nominal: assert property (@(posedge hclk) disable iff (!hresetn)
        (decide && s.phase <= PHASE_LIMIT && s.phase >= -PHASE_LIMIT) |=> s.pairs == PAIRS_NOMINAL)
        else $error("nominal phase did not give one pad pair");
    chk_stuff_drift: assert property (@(posedge hclk) disable iff (!hresetn)
        decide |=> (s.pairs == ($past(s.phase) > PHASE_LIMIT ? PAIRS_NONE :
            ($past(s.phase) < -PHASE_LIMIT ? PAIRS_BOTH : PAIRS_NOMINAL))))
        else $error("pad pairs do not follow phase");

endmodule : oplff_stuff_ctl
`default_nettype wire

// ### bench/oplff_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module oplff_far_end
#(
    parameter logic [13:0] SYNC_WORD = 14'h3F00
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // line from the framer
    input wire logic line_in,
    // line toward the framer
    output logic line_out,
    output logic frame_start,
    // capture status
    output logic [14:0] last_len,
    output logic [15:0] sync_count
);
    logic [13:0] sh_r;
    logic [14:0] cnt_r;
    logic [14:0] rpos_r;
    logic cap [1:13922];

    // hunt for the sync word, measure frames, store each bit after the sync word at its position
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sh_r <= 14'h0000;
            cnt_r <= 15'h0000;
            last_len <= 15'h0000;
            sync_count <= 16'h0000;
        end
        else
        begin
            sh_r <= {sh_r[12:0], line_in};
            if ({sh_r[12:0], line_in} == SYNC_WORD)
            begin
                last_len <= cnt_r - 15'h000D;
                sync_count <= sync_count + 16'h0001;
                cnt_r <= 15'h000E;
            end
            else
            begin
                cnt_r <= cnt_r + 15'h0001;
                if (cnt_r < 15'h3662)
                    cap[cnt_r + 15'h0001] <= line_in;
            end
        end
    end

    // send nominal frames with loss, power a, ready and first payload bit set
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rpos_r <= 15'h0001;
            line_out <= 1'b1;
            frame_start <= 1'b0;
        end
        else
        begin
            line_out <= (rpos_r == 15'h000F) || (rpos_r == 15'h0011) || (rpos_r == 15'h0DA3) ||
                (rpos_r == 15'h28D0);
            frame_start <= (rpos_r == 15'h0001);
            rpos_r <= (rpos_r == 15'h3660) ? 15'h0001 : rpos_r + 15'h0001;
        end
    end
endmodule : oplff_far_end
`default_nettype wire

// ### bench/tb_one_pair_line_frame_formatter.sv
`timescale 1ns/1ps
`default_nettype none
module tb_one_pair_line_frame_formatter;
    import oplff_pkg::*;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, mode;
    logic [2:0] hsize;
    logic tx_pay_take, tx_line_bit;
    logic tx_pay_bit = 1'b0;
    logic app_bit_strobe = 1'b0;
    logic rx_line_bit, rx_frame_start, rx_pay_bit, rx_pay_valid;
    logic [7:0] sq;
    logic [14:0] last_len;
    logic [14:0] rx_cnt = 15'h0000;
    logic [14:0] rx_last = 15'h0000;
    logic [1:0] rx_head = 2'h0;
    logic [15:0] sync_count;
    int pos_tab [12] = '{15, 16, 3485, 3486, 3489, 3491, 3492, 6969, 10444, 10448, 13919, 13920};
    logic exp_tab [12] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
    int bad_count = 0;
    int checks = 0;

    always #10 hclk = ~hclk;
    assign hready = hreadyout;

    oplff_framer u_oplff_framer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tx_pay_bit(tx_pay_bit), .app_bit_strobe(app_bit_strobe),
        .tx_pay_take(tx_pay_take), .tx_line_bit(tx_line_bit), .rx_line_bit(rx_line_bit),
        .rx_frame_start(rx_frame_start), .rx_pay_bit(rx_pay_bit), .rx_pay_valid(rx_pay_valid),
        .signal_quality_estimate(sq));
    oplff_far_end u_oplff_far_end (.hclk(hclk), .hresetn(hresetn), .line_in(tx_line_bit), .line_out(rx_line_bit),
        .frame_start(rx_frame_start), .last_len(last_len), .sync_count(sync_count));

    // application side: strobes follow takes, run fast or stop; payload alternates; count received payload
    // and keep its first two bits
    always @(posedge hclk)
    begin
        app_bit_strobe <= (mode == 2'h0) ? tx_pay_take : (mode == 2'h1);
        if (tx_pay_take === 1'b1)
            tx_pay_bit <= ~tx_pay_bit;
        if (rx_frame_start === 1'b1)
        begin
            rx_last <= rx_cnt;
            rx_cnt <= 15'h0000;
        end
        else if (rx_pay_valid === 1'b1)
        begin
            rx_cnt <= rx_cnt + 15'h0001;
            if (rx_cnt < 15'h0002)
                rx_head[rx_cnt[0]] <= rx_pay_bit;
        end
    end

    task ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb_xfer

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic [31:0] cb(input int p);
        return {31'h0, u_oplff_far_end.cap[p]};
    endfunction : cb

    task wait_sync();
        logic [15:0] k;
        int i;
        repeat (2)
        begin
            k = sync_count;
            i = 0;
            while (sync_count === k && i < 20000)
            begin
                @(posedge hclk);
                i++;
            end
            if (sync_count === k)
                bad_count++;
        end
    endtask : wait_sync

    task finish_test();
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    // main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        sq = 8'hA5;
        mode = 2'h0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        ahb_xfer(1'b0, ADDR_CTRL, 32'h0, rd);
        chk("ctrl", 32'h00000000, rd);
        ahb_xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        chk("status", 32'h000001A5, rd);
        ahb_xfer(1'b0, 8'h20, 32'h0, rd);
        chk("unmapped", 32'h00000000, rd);
        ahb_xfer(1'b1, ADDR_TXOVH, 32'h00003001, rd);
        ahb_xfer(1'b1, ADDR_CTRL, 32'h00000917, rd);
        chk("resp", 32'h00000000, {31'h0, hresp});
        ahb_xfer(1'b0, ADDR_TXOVH, 32'h0, rd);
        chk("txovh", 32'h00003001, rd);
        ahb_xfer(1'b0, ADDR_CTRL, 32'h0, rd);
        chk("ctrl", 32'h00000917, rd);
        wait_sync();
        chk("len nominal", 32'd13920, {17'h0, last_len});
        for (int n = 0; n < 12; n++)
            chk($sformatf("bit %0d", pos_tab[n]), {31'h0, exp_tab[n]}, cb(pos_tab[n]));
        chk("pay 18", ~cb(17) & 32'h1, cb(18));
        chk("pay 3495", ~cb(3484) & 32'h1, cb(3495));
        chk("pay 6973", ~cb(6962) & 32'h1, cb(6973));
        chk("pay 10451", ~cb(10440) & 32'h1, cb(10451));
        chk("pay 13918", ~cb(17) & 32'h1, cb(13918));
        ahb_xfer(1'b1, ADDR_CTRL, 32'h00000915, rd);
        mode <= 2'h1;
        wait_sync();
        chk("len fast", 32'd13918, {17'h0, last_len});
        chk("bit 3491", 32'h1, cb(3491));
        chk("bit 3492", 32'h1, cb(3492));
        ahb_xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        chk("pairs fast", {30'h0, PAIRS_NONE}, {30'h0, rd[9:8]});
        mode <= 2'h2;
        wait_sync();
        chk("len slow", 32'd13922, {17'h0, last_len});
        chk("bit 13921", 32'h1, cb(13921));
        chk("bit 13922", 32'h1, cb(13922));
        ahb_xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        chk("pairs slow", {30'h0, PAIRS_BOTH}, {30'h0, rd[9:8]});
        ahb_xfer(1'b0, ADDR_RXOVH, 32'h0, rd);
        chk("rx overhead", 32'h20000101, rd);
        chk("rx payload", 32'd13872, {17'h0, rx_last});
        chk("rx head", 32'h00000001, {30'h0, rx_head});
        ahb_xfer(1'b0, ADDR_PHASE, 32'h0, rd);
        chk("phase sign", 32'h00000001, {31'h0, rd[15]});
        finish_test();
    end

    // watchdog
    initial
    begin
        repeat (90000) @(posedge hclk);
        bad_count++;
        finish_test();
    end
endmodule : tb_one_pair_line_frame_formatter
`default_nettype wire
